// file: rtl/pdcl_defs.svh
// Timing constants for the current-limit sequencer
`ifndef PDCL_DEFS_SVH
`define PDCL_DEFS_SVH
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PDCL_CLK_MHZ 250
`define PDCL_QUAL_US 150
`define PDCL_QUAL_CYC (`PDCL_QUAL_US * `PDCL_CLK_MHZ)
`endif

// file: rtl/pdcl_pkg.sv
// Types for the current-limit sequencer
package pdcl_pkg;
  typedef enum logic [2:0] {
    PDCL_RESET,
    PDCL_INRUSH,
    PDCL_OPER,
    PDCL_THERMAL_OFF
  } pdcl_state_e;
endpackage

// file: rtl/pdcl_qual_timer.sv
// Qualification timer: condition held for a number of cycles
module pdcl_qual_timer #(
  parameter int COUNT = 37500
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic cond,
  output logic done
);
  localparam int W = $clog2(COUNT + 1);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb
  begin
    cnt_d = cnt_q;
    if (clear || !cond)
    begin
      cnt_d = '0;
    end
    else if (cnt_q != W'(COUNT))
    begin
      cnt_d = cnt_q + W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  assign done = cond && !clear && (cnt_q == W'(COUNT));
endmodule

// file: rtl/pdcl_sequencer.sv
// Inrush/operational current-limit state machine of a powered device
`include "pdcl_defs.svh"

module pdcl_sequencer #(
  parameter int QUAL_CYCLES = `PDCL_QUAL_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic supply_above_uvlo_on,
  input wire logic supply_above_uvlo_off,
  input wire logic inrush_below_limit,
  input wire logic in_current_limit,
  input wire logic drop_above_10v,
  input wire logic thermal_trip,
  output logic pass_switch_on,
  output logic inrush_limit_sel,
  output logic power_good_out_o,
  output logic power_good_out_oe,
  output logic load_return_node_oe
);
  import pdcl_pkg::*;

  // ----------------------------------------------------------------
  // Qualification timers
  // ----------------------------------------------------------------
  pdcl_state_e state_q;
  pdcl_state_e state_d;
  logic inrush_done;
  logic hard_done;

  // Both timers run only in their own states; leaving clears them
  pdcl_qual_timer #(.COUNT(QUAL_CYCLES)) u_inrush_tmr (
    .clk(clk),
    .rst(rst),
    .clear(state_q != PDCL_INRUSH),
    .cond(inrush_below_limit),
    .done(inrush_done)
  );

  pdcl_qual_timer #(.COUNT(QUAL_CYCLES)) u_hard_tmr (
    .clk(clk),
    .rst(rst),
    .clear(state_q != PDCL_OPER),
    .cond(in_current_limit && drop_above_10v),
    .done(hard_done)
  );

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    if (!supply_above_uvlo_off)
    begin
      state_d = PDCL_RESET;
    end
    else
    begin
      unique case (state_q)
        PDCL_RESET:
        begin
          if (supply_above_uvlo_on)
          begin
            state_d = PDCL_INRUSH;
          end
        end
        PDCL_INRUSH:
        begin
          if (thermal_trip)
          begin
            state_d = PDCL_THERMAL_OFF;
          end
          else if (inrush_done && !drop_above_10v)
          begin
            state_d = PDCL_OPER;
          end
        end
        PDCL_OPER:
        begin
          // Soft overload simply stays here
          if (thermal_trip)
          begin
            state_d = PDCL_THERMAL_OFF;
          end
          else if (hard_done)
          begin
            state_d = PDCL_INRUSH;
          end
        end
        PDCL_THERMAL_OFF:
        begin
          // Trip flag carries comparator hysteresis; no retry limit
          if (!thermal_trip)
          begin
            state_d = drop_above_10v ? PDCL_INRUSH : PDCL_OPER;
          end
        end
        default:
        begin
          state_d = PDCL_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= PDCL_RESET;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic sw_d;
  logic inr_d;
  logic pg_pull_d;

  always_comb
  begin
    sw_d = (state_d == PDCL_INRUSH) || (state_d == PDCL_OPER);
    inr_d = (state_d != PDCL_OPER);
    // Pull-down when off, in inrush, or high drop
    pg_pull_d = !sw_d || inr_d || drop_above_10v;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pass_switch_on <= 1'b0;
      inrush_limit_sel <= 1'b1;
      power_good_out_oe <= 1'b1;
      load_return_node_oe <= 1'b0;
    end
    else
    begin
      pass_switch_on <= sw_d;
      inrush_limit_sel <= inr_d;
      power_good_out_oe <= pg_pull_d;
      load_return_node_oe <= sw_d;
    end
  end

  // Open-drain: only ever drives low
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      power_good_out_o <= 1'b0;
    end
    else
    begin
      power_good_out_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_uvlo_low;
    !supply_above_uvlo_off;
  endsequence

  a_uvlo_off: assert property (@(posedge clk) disable iff (rst)
    s_uvlo_low |=> !pass_switch_on && !load_return_node_oe)
    else $error("switch on below UVLO");

  a_turn_on: assert property (@(posedge clk) disable iff (rst)
    (state_q == PDCL_RESET && supply_above_uvlo_on && supply_above_uvlo_off)
    |=> pass_switch_on && inrush_limit_sel)
    else $error("no inrush turn-on");

  a_oper_good: assert property (@(posedge clk) disable iff (rst)
    (pass_switch_on && !inrush_limit_sel && !drop_above_10v && supply_above_uvlo_off
     && !thermal_trip && state_q == PDCL_OPER && !hard_done)
    |=> !power_good_out_oe)
    else $error("power-good not released");

  a_thermal_off: assert property (@(posedge clk) disable iff (rst)
    (supply_above_uvlo_off && thermal_trip && state_q != PDCL_RESET)
    |=> !pass_switch_on && power_good_out_oe)
    else $error("thermal did not switch off");

  a_pg_pull: assert property (@(posedge clk) disable iff (rst)
    (!pass_switch_on || inrush_limit_sel) |-> power_good_out_oe)
    else $error("power-good released while off or in inrush");

  a_hard_fold: assert property (@(posedge clk) disable iff (rst)
    (state_q == PDCL_OPER && hard_done && supply_above_uvlo_off && !thermal_trip)
    |=> inrush_limit_sel && power_good_out_oe)
    else $error("no fallback on hard overload");

  a_rehigh: assert property (@(posedge clk) disable iff (rst)
    (state_q == PDCL_THERMAL_OFF && !thermal_trip && drop_above_10v
     && supply_above_uvlo_off) |=> inrush_limit_sel && pass_switch_on)
    else $error("bad re-enable with high drop");

  a_relow: assert property (@(posedge clk) disable iff (rst)
    (state_q == PDCL_THERMAL_OFF && !thermal_trip && !drop_above_10v
     && supply_above_uvlo_off) |=> !inrush_limit_sel && !power_good_out_oe)
    else $error("bad re-enable with low drop");
endmodule

// file: bench/pdcl_far_side.sv
// Downstream converter model fed by the open-drain power-good line
module pdcl_far_side (
  input wire logic pg_data,
  input wire logic pg_pull_low,
  output logic converter_en
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-up keeps the line high when released; converter_en follows pg_data while pg_pull_low is 1
  // Converter starts only once power-good is released
  assign converter_en = pg_pull_low ? pg_data : 1'b1;
endmodule

// file: bench/pdcl_sequencer_tb_top.sv
// Self-checking bench of the current-limit sequencer
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
  $display("Error t=%0t got=%h exp=%h", $time, a, b); end end
module pdcl_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  // {uvlo_on, uvlo_off, inrush_below, in_limit, drop_high, thermal}
  logic [5:0] in = 6'h00;
  logic sw, sel, pg_o, pg_oe, ret_oe, conv_en;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #2 clk = ~clk;
  pdcl_sequencer #(.QUAL_CYCLES(20)) i_dut (
    .clk(clk), .rst(rst),
    .supply_above_uvlo_on(in[5]), .supply_above_uvlo_off(in[4]),
    .inrush_below_limit(in[3]), .in_current_limit(in[2]),
    .drop_above_10v(in[1]), .thermal_trip(in[0]),
    .pass_switch_on(sw), .inrush_limit_sel(sel), .power_good_out_o(pg_o),
    .power_good_out_oe(pg_oe), .load_return_node_oe(ret_oe)
  );
  pdcl_far_side i_far (.pg_data(pg_o), .pg_pull_low(pg_oe), .converter_en(conv_en));
  task automatic results();
    $display("Comparisons %0d, errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Hold an input pattern for n cycles, changing just after the edge
  task automatic apply(input logic [5:0] v, input int n);
    in = v;
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [4:0] exp);
    `CHK({sw, sel, pg_o, pg_oe, ret_oe}, exp)
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 2000)
    begin
      n_errors++;
      results();
    end
  end
  initial
  begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    chk(5'h0a);
    apply(6'h30, 2);
    chk(5'h1b);
    `CHK(conv_en, 1'b0)
    apply(6'h38, 10);
    apply(6'h30, 1);
    apply(6'h38, 15);
    chk(5'h1b);
    apply(6'h38, 10);
    chk(5'h11);
    `CHK(conv_en, 1'b1)
    apply(6'h34, 30);
    chk(5'h11);
    apply(6'h36, 10);
    chk(5'h13);
    apply(6'h36, 15);
    chk(5'h1b);
    apply(6'h38, 25);
    chk(5'h11);
    apply(6'h39, 3);
    `CHK({sw, pg_oe, ret_oe}, 3'h2)
    apply(6'h38, 3);
    chk(5'h11);
    apply(6'h3b, 3);
    apply(6'h3a, 3);
    chk(5'h1b);
    apply(6'h38, 25);
    chk(5'h11);
    apply(6'h09, 3);
    chk(5'h0a);
    apply(6'h18, 5);
    chk(5'h0a);
    results();
  end
endmodule
